// ---- hdl/cid_defines.svh ----
// constants shared by the instruction-read / ownership-read coherence directory logic
`ifndef CID_DEFINES_SVH
`define CID_DEFINES_SVH
`define CID_ID_W 4
`define CID_ENTRIES 4
`define CID_AW 32
`define CID_DW 64
`define CID_RESP_BIT 3
`endif

// ---- hdl/cid_entry_table.sv ----
// transaction entry table: allocation, arrival flags and lookup
`timescale 1ns/1ns
`default_nettype none
`include "cid_defines.svh"
module cid_entry_table
  import cid_pkg::*;
#(
  parameter int ENTRIES = `CID_ENTRIES,
  parameter int AW = `CID_AW,
  parameter int IDW = `CID_ID_W,
  localparam int EW = $clog2(ENTRIES)
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic alloc,
  input wire cid_role_e alloc_role,
  input wire logic [AW-1:0] alloc_addr,
  input wire logic [IDW-1:0] alloc_orig,
  output logic [EW-1:0] alloc_idx,
  output logic full,
  input wire logic [EW-1:0] ent_idx,
  input wire logic free,
  input wire logic set_done,
  input wire logic set_data,
  output logic look_valid,
  output cid_role_e look_role,
  output logic [AW-1:0] look_addr,
  output logic [IDW-1:0] look_orig,
  output logic look_done,
  output logic look_data
);
  logic [ENTRIES-1:0] vld;
  logic [ENTRIES-1:0] fdone;
  logic [ENTRIES-1:0] fdata;
  cid_role_e role_a [ENTRIES];
  logic [AW-1:0] addr_a [ENTRIES];
  logic [IDW-1:0] orig_a [ENTRIES];

  // lowest free entry wins
  always_comb
  begin
    alloc_idx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--)
    begin
      if (!vld[i])
        alloc_idx = EW'(i);
    end
  end
  assign full = &vld;

  for (genvar g = 0; g < ENTRIES; g++)
  begin : g_ent
    logic v, d, a;
    cid_role_e r;
    logic [AW-1:0] ad;
    logic [IDW-1:0] o;
    wire logic hit_alloc = alloc && alloc_idx == EW'(g);
    wire logic hit = ent_idx == EW'(g);
    always_ff @(posedge mclk)
    begin
      if (rst)
      begin
        v <= 1'b0;
        d <= 1'b0;
        a <= 1'b0;
      end
      else
      begin
        v <= hit_alloc | (v & ~(free & hit));
        d <= ~hit_alloc & (d | (set_done & hit));
        a <= ~hit_alloc & (a | (set_data & hit));
      end
    end
    always_ff @(posedge mclk)
    begin
      if (hit_alloc)
      begin
        r <= alloc_role;
        ad <= alloc_addr;
        o <= alloc_orig;
      end
    end
    assign vld[g] = v;
    assign fdone[g] = d;
    assign fdata[g] = a;
    assign role_a[g] = r;
    assign addr_a[g] = ad;
    assign orig_a[g] = o;
  end

  assign look_valid = vld[ent_idx];
  assign look_role = role_a[ent_idx];
  assign look_addr = addr_a[ent_idx];
  assign look_orig = orig_a[ent_idx];
  assign look_done = fdone[ent_idx];
  assign look_data = fdata[ent_idx];
endmodule : cid_entry_table
`default_nettype wire

// ---- hdl/cid_pkg.sv ----
// types for the coherence directory block
package cid_pkg;
  typedef enum logic [2:0]
  {
    CID_DIR_LM = 3'h0,
    CID_DIR_LS = 3'h1,
    CID_DIR_SH = 3'h2,
    CID_DIR_RM = 3'h3
  } cid_dir_e;
  typedef enum logic [1:0]
  {
    CID_ANS_NONE = 2'h0,
    CID_ANS_SHARED = 2'h1,
    CID_ANS_EXCL = 2'h2,
    CID_ANS_RETRY = 2'h3
  } cid_ans_e;
  typedef enum logic [3:0]
  {
    CID_M_IREAD_HOME = 4'h0,
    CID_M_READ_OWNER = 4'h1,
    CID_M_RTO_HOME = 4'h2,
    CID_M_RTO_OWNER = 4'h3,
    CID_M_DKILL_SHARER = 4'h4,
    CID_M_DONE = 4'h8,
    CID_M_DONE_INTV = 4'h9,
    CID_M_DATA_ONLY = 4'hA,
    CID_M_INTERVENTION = 4'hB,
    CID_M_NOT_OWNER = 4'hC,
    CID_M_RETRY = 4'hD
  } cid_msg_e;
  typedef enum logic [1:0]
  {
    CID_ROLE_IREQ = 2'h0,
    CID_ROLE_RFO = 2'h1,
    CID_ROLE_HOME = 2'h2,
    CID_ROLE_SELF = 2'h3
  } cid_role_e;
  typedef enum logic
  {
    CID_PW_IDLE = 1'b0,
    CID_PW_WAIT = 1'b1
  } cid_pw_e;
endpackage : cid_pkg

// ---- hdl/cid_push_wait.sv ----
// holds an incoming instruction read while the local caches push a modified line
`timescale 1ns/1ns
`default_nettype none
module cid_push_wait
  import cid_pkg::*;
#(
  parameter int AW = 32,
  parameter int IDW = 4,
  parameter int MW = 16
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic [IDW-1:0] start_src,
  input wire logic [AW-1:0] start_addr,
  input wire logic [MW-1:0] start_mask,
  input wire logic rd_done,
  output logic busy,
  output logic rd_valid,
  output logic fin,
  output logic [IDW-1:0] hold_src,
  output logic [AW-1:0] hold_addr,
  output logic [MW-1:0] hold_mask
);
  cid_pw_e state;
  cid_pw_e next_state;

  assign busy = state == CID_PW_WAIT;
  assign fin = busy & rd_done;

  always_comb
  begin
    case (state)
      CID_PW_IDLE: next_state = start ? CID_PW_WAIT : CID_PW_IDLE;
      CID_PW_WAIT: next_state = rd_done ? CID_PW_IDLE : CID_PW_WAIT;
      default: next_state = CID_PW_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= CID_PW_IDLE;
      rd_valid <= 1'b0;
      hold_src <= '0;
      hold_addr <= '0;
      hold_mask <= '0;
    end
    else
    begin
      state <= next_state;
      rd_valid <= start & ~busy;
      if (start & ~busy)
      begin
        hold_src <= start_src;
        hold_addr <= start_addr;
        hold_mask <= start_mask;
      end
    end
  end
endmodule : cid_push_wait
`default_nettype wire

// ---- hdl/cid_top.sv ----
// coherence directory logic for instruction reads and local ownership reads
`timescale 1ns/1ns
`default_nettype none
`include "cid_defines.svh"
module cid_top
  import cid_pkg::*;
#(
  parameter int ID_W = `CID_ID_W,
  parameter int ENTRIES = `CID_ENTRIES,
  parameter int AW = `CID_AW,
  parameter int DW = `CID_DW,
  localparam int MW = 1 << ID_W,
  localparam int EW = $clog2(ENTRIES)
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ID_W-1:0] local_element_id,
  input wire logic preq_valid,
  input wire logic preq_rfo,
  input wire logic [AW-1:0] preq_addr,
  input wire logic preq_collision,
  input wire logic preq_home_local,
  input wire logic [ID_W-1:0] home_memory_element,
  input wire cid_dir_e preq_dir_state,
  input wire logic [MW-1:0] preq_dir_mask,
  input wire logic [ID_W-1:0] directory_owner_target,
  input wire logic [DW-1:0] preq_mem_data,
  output var cid_ans_e pans_answer,
  output logic pans_valid,
  output logic pans_data_valid,
  output logic [DW-1:0] pans_data,
  input wire logic rx_valid,
  input wire cid_msg_e rx_type,
  input wire logic [ID_W-1:0] rx_srcid,
  input wire logic [EW-1:0] rx_entry,
  input wire logic [AW-1:0] rx_addr,
  input wire logic rx_collision,
  input wire logic [DW-1:0] rx_data,
  input wire cid_dir_e rx_dir_state,
  input wire logic [MW-1:0] rx_dir_mask,
  input wire logic [ID_W-1:0] rx_owner_target,
  input wire logic [DW-1:0] rx_mem_data,
  output logic rx_ready,
  output logic tx_valid,
  output var cid_msg_e tx_type,
  output logic [ID_W-1:0] tx_dest,
  output logic tx_mcast,
  output logic [MW-1:0] tx_mask,
  output logic [ID_W-1:0] tx_secid,
  output logic [EW-1:0] tx_entry,
  output logic tx_with_data,
  output logic [DW-1:0] tx_data,
  output logic fill_valid,
  output logic [AW-1:0] fill_addr,
  output logic [DW-1:0] fill_data,
  output logic dir_wr_valid,
  output logic [AW-1:0] dir_wr_addr,
  output var cid_dir_e dir_wr_state,
  output logic [MW-1:0] dir_wr_mask,
  output logic mem_wr_valid,
  output logic [AW-1:0] mem_wr_addr,
  output logic [DW-1:0] mem_wr_data,
  output logic cache_rd_valid,
  output logic [AW-1:0] cache_rd_addr,
  input wire logic cache_rd_done,
  input wire logic [DW-1:0] cache_rd_data,
  output logic coll_escalate,
  output logic err
);
  // ****************************************************************
  // shared decode
  // ****************************************************************
  logic [EW-1:0] alloc_idx;
  logic tbl_full, look_valid, look_done, look_data;
  cid_role_e look_role;
  logic [AW-1:0] look_addr;
  logic [ID_W-1:0] look_orig;
  logic pw_busy, pw_fin;
  logic [ID_W-1:0] pw_src;
  logic [MW-1:0] pw_mask;
  wire logic rx_take = rx_valid & rx_ready;
  wire logic rx_is_resp = rx_type[`CID_RESP_BIT];
  wire logic [MW-1:0] self_bit = MW'(1) << local_element_id;
  wire logic [MW-1:0] src_bit = MW'(1) << rx_srcid;
  wire logic [MW-1:0] orig_bit = MW'(1) << look_orig;
  // a collision, or external work owning the directory port this cycle, means the processor must retry
  wire logic pr_hazard = preq_collision | rx_take | pw_fin;
  wire logic pr_need_entry = ~preq_home_local | preq_dir_state == CID_DIR_RM
                             | (preq_rfo & preq_dir_state == CID_DIR_SH);

  // ****************************************************************
  // processor request decode
  // ****************************************************************
  cid_ans_e p_ans;
  cid_msg_e p_type;
  cid_role_e p_role;
  logic p_data, p_tx, p_mcast, p_dirw, p_err;
  logic [ID_W-1:0] p_dest;
  always_comb
  begin
    p_ans = CID_ANS_NONE;
    p_type = CID_M_IREAD_HOME;
    p_role = CID_ROLE_IREQ;
    p_data = 1'b0;
    p_tx = 1'b0;
    p_mcast = 1'b0;
    p_dirw = 1'b0;
    p_err = 1'b0;
    p_dest = home_memory_element;
    if (!preq_valid)
      p_ans = CID_ANS_NONE;
    else if (pr_hazard || (pr_need_entry && tbl_full))
      p_ans = CID_ANS_RETRY;
    else if (!preq_home_local)
    begin
      p_ans = CID_ANS_RETRY;
      p_tx = 1'b1;
      p_type = preq_rfo ? CID_M_RTO_HOME : CID_M_IREAD_HOME;
      p_role = preq_rfo ? CID_ROLE_RFO : CID_ROLE_IREQ;
    end
    else
    begin
      case (preq_dir_state)
        CID_DIR_LM:
        begin
          p_ans = CID_ANS_EXCL;
          p_data = 1'b1;
        end
        CID_DIR_LS:
        begin
          p_ans = preq_rfo ? CID_ANS_EXCL : CID_ANS_SHARED;
          p_data = 1'b1;
          p_dirw = preq_rfo;
        end
        CID_DIR_SH:
        begin
          p_ans = preq_rfo ? CID_ANS_RETRY : CID_ANS_SHARED;
          p_data = ~preq_rfo;
          p_tx = preq_rfo;
          p_mcast = preq_rfo;
          p_type = CID_M_DKILL_SHARER;
          p_role = CID_ROLE_RFO;
        end
        CID_DIR_RM:
        begin
          p_ans = preq_rfo ? CID_ANS_RETRY : CID_ANS_SHARED;
          p_tx = 1'b1;
          p_type = preq_rfo ? CID_M_RTO_OWNER : CID_M_READ_OWNER;
          p_dest = directory_owner_target;
          p_role = preq_rfo ? CID_ROLE_RFO : CID_ROLE_SELF;
        end
        default: p_err = 1'b1;
      endcase
    end
  end

  // ****************************************************************
  // incoming request and response decode
  // ****************************************************************
  cid_msg_e r_type;
  cid_dir_e r_dstate;
  logic r_tx, r_wd, r_dirw, r_memw, r_fill, r_free, r_sdone, r_sdata;
  logic r_alloc, r_coll, r_err, r_pw, r_reqaddr, r_entry_alloc;
  logic [ID_W-1:0] r_dest, r_sec;
  logic [MW-1:0] r_dmask;
  logic [DW-1:0] r_data;
  always_comb
  begin
    r_type = CID_M_DONE;
    r_dstate = CID_DIR_SH;
    {r_tx, r_wd, r_dirw, r_memw, r_fill, r_free, r_sdone, r_sdata} = '0;
    {r_alloc, r_coll, r_err, r_pw, r_reqaddr, r_entry_alloc} = '0;
    r_dest = rx_srcid;
    r_sec = local_element_id;
    r_dmask = rx_dir_mask | src_bit;
    r_data = rx_mem_data;
    if (rx_take && !rx_is_resp)
    begin
      r_reqaddr = 1'b1;
      if (rx_collision)
        r_coll = 1'b1;
      else if (rx_type != CID_M_IREAD_HOME)
        r_err = 1'b1;
      else
      begin
        case (rx_dir_state)
          CID_DIR_LM: r_pw = 1'b1;
          CID_DIR_LS, CID_DIR_SH:
          begin
            {r_dirw, r_tx, r_wd} = 3'h7;
          end
          CID_DIR_RM:
          begin
            // third-party intervention: ask the owner and remember who asked, or retry the requester when the table is full
            r_err = rx_owner_target == rx_srcid;
            r_tx = ~r_err;
            r_type = tbl_full ? CID_M_RETRY : CID_M_READ_OWNER;
            r_alloc = ~r_err & ~tbl_full;
            r_entry_alloc = r_alloc;
            r_dest = tbl_full ? rx_srcid : rx_owner_target;
            r_sec = rx_srcid;
          end
          default: r_err = 1'b1;
        endcase
      end
    end
    else if (rx_take && !look_valid)
      r_err = 1'b1;
    else if (rx_take)
    begin
      r_dmask = rx_dir_mask | orig_bit;
      r_dest = look_orig;
      case (look_role)
        CID_ROLE_HOME:
        begin
          if (rx_type == CID_M_INTERVENTION)
          begin
            {r_memw, r_dirw, r_tx, r_wd, r_free} = 5'h1F;
            r_data = rx_data;
          end
          else if (rx_type == CID_M_NOT_OWNER || rx_type == CID_M_RETRY)
          begin
            case (rx_dir_state)
              CID_DIR_LS, CID_DIR_LM: {r_dirw, r_tx, r_wd, r_free} = 4'hF;
              CID_DIR_RM:
              begin
                r_tx = 1'b1;
                r_type = CID_M_READ_OWNER;
                r_dest = rx_srcid;
              end
              default: r_err = 1'b1;
            endcase
          end
          else
            r_err = 1'b1;
        end
        CID_ROLE_IREQ:
        begin
          case (rx_type)
            CID_M_DONE: {r_fill, r_free} = 2'h3;
            CID_M_DONE_INTV: {r_sdone, r_free} = {1'b1, look_data};
            CID_M_DATA_ONLY: {r_fill, r_sdata, r_free} = {2'h3, look_done};
            CID_M_RETRY:
            begin
              r_tx = 1'b1;
              r_type = CID_M_IREAD_HOME;
              r_dest = rx_srcid;
            end
            default: r_err = 1'b1;
          endcase
        end
        // home and original requester at once, or ownership-read replies
        default: r_err = 1'b1;
      endcase
    end
  end

  // ****************************************************************
  // submodules
  // ****************************************************************
  cid_entry_table #(.ENTRIES(ENTRIES), .AW(AW), .IDW(ID_W)) u_table
  (
    .mclk(mclk),
    .rst(rst),
    .alloc(p_tx | r_alloc),
    .alloc_role(rx_take ? CID_ROLE_HOME : p_role),
    .alloc_addr(rx_take ? rx_addr : preq_addr),
    .alloc_orig(rx_take ? rx_srcid : local_element_id),
    .alloc_idx(alloc_idx),
    .full(tbl_full),
    .ent_idx(rx_entry),
    .free(r_free),
    .set_done(r_sdone),
    .set_data(r_sdata),
    .look_valid(look_valid),
    .look_role(look_role),
    .look_addr(look_addr),
    .look_orig(look_orig),
    .look_done(look_done),
    .look_data(look_data)
  );

  cid_push_wait #(.AW(AW), .IDW(ID_W), .MW(MW)) u_push
  (
    .mclk(mclk),
    .rst(rst),
    .start(r_pw),
    .start_src(rx_srcid),
    .start_addr(rx_addr),
    .start_mask(rx_dir_mask | src_bit),
    .rd_done(cache_rd_done),
    .busy(pw_busy),
    .rd_valid(cache_rd_valid),
    .fin(pw_fin),
    .hold_src(pw_src),
    .hold_addr(cache_rd_addr),
    .hold_mask(pw_mask)
  );

  // ****************************************************************
  // output selection and registers
  // ****************************************************************
  wire logic next_tx_valid = p_tx | r_tx | pw_fin;
  wire cid_msg_e next_tx_type = pw_fin ? CID_M_DONE : (rx_take ? r_type : p_type);
  wire logic [ID_W-1:0] next_tx_dest = pw_fin ? pw_src : (rx_take ? r_dest : p_dest);
  wire logic [MW-1:0] next_tx_mask = preq_dir_mask & ~self_bit;
  wire logic [ID_W-1:0] next_tx_secid = rx_take ? r_sec : local_element_id;
  wire logic [EW-1:0] next_tx_entry = (p_tx | r_entry_alloc) ? alloc_idx : rx_entry;
  wire logic next_tx_wd = pw_fin | r_wd;
  wire logic [DW-1:0] next_tx_data = pw_fin ? cache_rd_data : r_data;
  wire logic next_dirw = pw_fin | r_dirw | p_dirw;
  wire logic [AW-1:0] next_dir_addr = pw_fin ? cache_rd_addr
                                      : (!rx_take ? preq_addr : (r_reqaddr ? rx_addr : look_addr));
  wire cid_dir_e next_dir_state = (pw_fin | rx_take) ? r_dstate : CID_DIR_LM;
  wire logic [MW-1:0] next_dir_mask = pw_fin ? pw_mask : (rx_take ? r_dmask : preq_dir_mask);
  wire logic next_rx_ready = ~r_pw & ~(pw_busy & ~pw_fin);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      {pans_valid, pans_data_valid, tx_valid, tx_mcast, tx_with_data} <= '0;
      {fill_valid, dir_wr_valid, mem_wr_valid, coll_escalate, err, rx_ready} <= '0;
      pans_answer <= CID_ANS_NONE;
      tx_type <= CID_M_IREAD_HOME;
      dir_wr_state <= CID_DIR_LM;
      {pans_data, tx_data, fill_data, mem_wr_data} <= '0;
      {tx_dest, tx_secid, tx_entry, tx_mask, dir_wr_mask} <= '0;
      {fill_addr, dir_wr_addr, mem_wr_addr} <= '0;
    end
    else
    begin
      pans_valid <= preq_valid;
      pans_answer <= p_ans;
      pans_data_valid <= p_data;
      pans_data <= preq_mem_data;
      tx_valid <= next_tx_valid;
      tx_type <= next_tx_type;
      tx_dest <= next_tx_dest;
      tx_mcast <= p_mcast & ~rx_take;
      tx_mask <= next_tx_mask;
      tx_secid <= next_tx_secid;
      tx_entry <= next_tx_entry;
      tx_with_data <= next_tx_wd;
      tx_data <= next_tx_data;
      fill_valid <= r_fill;
      fill_addr <= look_addr;
      fill_data <= rx_data;
      dir_wr_valid <= next_dirw;
      dir_wr_addr <= next_dir_addr;
      dir_wr_state <= next_dir_state;
      dir_wr_mask <= next_dir_mask;
      mem_wr_valid <= r_memw;
      mem_wr_addr <= look_addr;
      mem_wr_data <= rx_data;
      coll_escalate <= r_coll;
      err <= p_err | r_err;
      rx_ready <= next_rx_ready;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_clean(logic rfo, cid_dir_e st);
    preq_valid && !pr_hazard && !tbl_full && preq_home_local && preq_rfo == rfo && preq_dir_state == st;
  endsequence
  sequence s_resp(cid_role_e ro, cid_msg_e ty);
    rx_take && rx_is_resp && look_valid && look_role == ro && rx_type == ty;
  endsequence

  a_collision_retry:
    assert property (preq_valid && preq_collision |=> pans_valid && pans_answer == CID_ANS_RETRY)
    else $error("colliding request not retried");
  a_iread_lm_excl:
    assert property (s_clean(1'b0, CID_DIR_LM) |=> pans_answer == CID_ANS_EXCL && pans_data_valid && !tx_valid)
    else $error("local modified ifetch not exclusive");
  a_iread_shared_keep:
    assert property (s_clean(1'b0, CID_DIR_SH) |=> pans_answer == CID_ANS_SHARED && pans_data_valid && !dir_wr_valid)
    else $error("shared ifetch wrong");
  a_iread_rm_owner:
    assert property (s_clean(1'b0, CID_DIR_RM) |=> tx_valid && tx_type == CID_M_READ_OWNER
                     && tx_dest == $past(directory_owner_target) && pans_answer == CID_ANS_SHARED)
    else $error("owner read not sent");
  a_remote_home_req:
    assert property (preq_valid && !pr_hazard && !tbl_full && !preq_home_local |=> pans_answer == CID_ANS_RETRY
                     && tx_valid && tx_dest == $past(home_memory_element)
                     && tx_type == ($past(preq_rfo) ? CID_M_RTO_HOME : CID_M_IREAD_HOME))
    else $error("home request not sent");
  a_self_home_err:
    assert property (s_resp(CID_ROLE_SELF, CID_M_DONE) |=> err && !tx_valid)
    else $error("self response not flagged");
  a_interv_done:
    assert property (s_resp(CID_ROLE_HOME, CID_M_INTERVENTION) |=> mem_wr_valid && tx_type == CID_M_DONE
                     && tx_dest == $past(look_orig) && dir_wr_state == CID_DIR_SH)
    else $error("intervention not completed");
  a_done_fill:
    assert property (s_resp(CID_ROLE_IREQ, CID_M_DONE) |=> fill_valid && !tx_valid)
    else $error("done did not fill");
  a_push_wait:
    assert property (rx_take && !rx_is_resp && !rx_collision && rx_type == CID_M_IREAD_HOME
                     && rx_dir_state == CID_DIR_LM |=> cache_rd_valid && !rx_ready && !tx_valid)
    else $error("push wait not started");
  a_rfo_ls_upgrade:
    assert property (s_clean(1'b1, CID_DIR_LS) |=> dir_wr_valid && dir_wr_state == CID_DIR_LM
                     && pans_answer == CID_ANS_EXCL)
    else $error("ownership upgrade missing");
  a_dkill_not_self:
    assert property (s_clean(1'b1, CID_DIR_SH) |=> tx_mcast && tx_type == CID_M_DKILL_SHARER
                     && (tx_mask & self_bit) == '0 && pans_answer == CID_ANS_RETRY)
    else $error("kill list includes self");
endmodule : cid_top
`default_nettype wire

// ---- test/cid_cache_model.sv ----
// cache-side partner that answers local reads after a delay
`timescale 1ns/1ns
`default_nettype none
module cid_cache_model
  import cid_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cache_rd_valid,
  output logic cache_rd_done,
  output logic [63:0] cache_rd_data
);
  logic [2:0] cnt;
  // slow answer, so the rx stall is seen
  always_ff @(posedge mclk)
  begin
    if (rst)
      cnt <= 3'h0;
    else if (cache_rd_valid)
      cnt <= 3'h4;
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end
  assign cache_rd_done = (cnt == 3'h1);
  // data is junk outside the done cycle
  assign cache_rd_data = cache_rd_done ? 64'hC0DE : {16{cnt, 1'b1}};
endmodule : cid_cache_model
`default_nettype wire

// ---- test/coherence_iread_rfo_directory_test.sv ----
// self-checking bench for the coherence directory block
`timescale 1ns/1ns
`default_nettype none
module coherence_iread_rfo_directory_test
  import cid_pkg::*;
;
  logic mclk, rst, preq_valid, preq_rfo, preq_collision, preq_home_local, rx_valid;
  logic pans_valid, rx_ready, tx_valid, tx_with_data, fill_valid, cache_rd_valid, cache_rd_done, err;
  logic [3:0] idx, tx_dest;
  logic dir_wr_valid, coll_escalate;
  logic [63:0] cache_rd_data;
  cid_dir_e preq_dir_state, rx_dir_state;
  cid_ans_e pans_answer;
  cid_msg_e rx_type, tx_type;
  logic [1:0] rx_entry;
  int mismatches = 0;
  int samples_checked = 0;
  // {rfo,home_local,collision,-} dir {tx,-,answer} tx_type
  logic [15:0] rows [11] = '{16'h2030, 16'h4020, 16'h4110, 16'h4210, 16'h4391, 16'h00B0,
    16'hC020, 16'hC120, 16'hC3B3, 16'hC2B4, 16'h8030};
  cid_top u_cid_top (.mclk(mclk), .rst(rst), .local_element_id(4'h1), .preq_valid(preq_valid),
    .preq_rfo(preq_rfo), .preq_addr({28'h0, idx}), .preq_collision(preq_collision),
    .preq_home_local(preq_home_local), .home_memory_element(4'h5), .preq_dir_state(preq_dir_state),
    .preq_dir_mask(16'h0006), .directory_owner_target(4'h7), .preq_mem_data({60'h0, idx}),
    .pans_answer(pans_answer), .pans_valid(pans_valid), .pans_data_valid(), .pans_data(),
    .rx_valid(rx_valid), .rx_type(rx_type), .rx_srcid(idx), .rx_entry(rx_entry), .rx_addr({28'h0, idx}),
    .rx_collision(preq_collision), .rx_data({60'h0, idx}), .rx_dir_state(rx_dir_state),
    .rx_dir_mask({12'h0, idx}), .rx_owner_target(~idx), .rx_mem_data({60'h0, idx}), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_type(tx_type), .tx_dest(tx_dest), .tx_mcast(), .tx_mask(), .tx_secid(), .tx_entry(),
    .tx_with_data(tx_with_data), .tx_data(), .fill_valid(fill_valid), .fill_addr(), .fill_data(),
    .dir_wr_valid(dir_wr_valid), .dir_wr_addr(), .dir_wr_state(), .dir_wr_mask(), .mem_wr_valid(), .mem_wr_addr(),
    .mem_wr_data(), .cache_rd_valid(cache_rd_valid), .cache_rd_addr(), .cache_rd_done(cache_rd_done),
    .cache_rd_data(cache_rd_data), .coll_escalate(coll_escalate), .err(err));
  cid_cache_model u_cid_cache_model (.mclk(mclk), .rst(rst), .cache_rd_valid(cache_rd_valid),
    .cache_rd_done(cache_rd_done), .cache_rd_data(cache_rd_data));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic req(input logic [15:0] r);
    @(negedge mclk);
    {preq_rfo, preq_home_local, preq_collision} = r[15:13];
    preq_dir_state = cid_dir_e'(r[10:8]);
    preq_valid = 1'b1;
    @(negedge mclk);
    preq_valid = 1'b0;
    cmp(pans_valid, 1'b1);
    cmp({2'h0, pans_answer}, {2'h0, r[5:4]});
    cmp(tx_valid, r[7]);
    if (r[7])
      cmp(tx_type, r[3:0]);
  endtask : req
  task automatic rxm(input cid_msg_e t, input logic [1:0] e);
    @(negedge mclk);
    cmp(rx_ready, 1'b1);
    rx_type = t;
    rx_entry = e;
    rx_valid = 1'b1;
    @(negedge mclk);
    rx_valid = 1'b0;
  endtask : rxm
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // ****************
  // main sequence
  // ****************
  initial
  begin
    rst = 1'b1;
    {preq_valid, preq_rfo, preq_collision, preq_home_local, rx_valid} = 5'h00;
    idx = 4'h0;
    rx_entry = 2'h0;
    rx_type = CID_M_DONE;
    rx_dir_state = CID_DIR_LM;
    preq_dir_state = CID_DIR_LM;
    repeat (3) @(negedge mclk);
    cmp(pans_valid, 1'b0);
    cmp(rx_ready, 1'b0);
    rst = 1'b0;
    @(negedge mclk);
    for (int i = 0; i < 11; i++)
    begin
      idx = 4'(i);
      req(rows[i]);
    end
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    req(16'h80B2);
    req(16'h00B0);
    rxm(CID_M_DATA_ONLY, 2'h1);
    cmp(fill_valid, 1'b1);
    rxm(CID_M_DONE_INTV, 2'h1);
    cmp(err, 1'b0);
    // entry 1 is freed now, so a repeat is a stray response
    rxm(CID_M_DONE_INTV, 2'h1);
    cmp(err, 1'b1);
    // entry 1 comes back with both arrival flags cleared by its new allocation
    req(16'h00B0);
    rxm(CID_M_DONE_INTV, 2'h1);
    rxm(CID_M_DATA_ONLY, 2'h1);
    cmp(err, 1'b0);
    cmp(fill_valid, 1'b1);
    rxm(CID_M_IREAD_HOME, 2'h2);
    cmp(cache_rd_valid, 1'b1);
    for (int n = 0; n < 20 && tx_valid !== 1'b1; n++)
      @(negedge mclk);
    cmp(tx_valid, 1'b1);
    cmp(tx_type, CID_M_DONE);
    cmp(tx_with_data, 1'b1);
    rx_dir_state = CID_DIR_SH;
    rxm(CID_M_IREAD_HOME, 2'h2);
    cmp(tx_type, CID_M_DONE);
    cmp(tx_dest, idx);
    cmp(dir_wr_valid, 1'b1);
    preq_collision = 1'b1;
    rxm(CID_M_IREAD_HOME, 2'h2);
    cmp(coll_escalate, 1'b1);
    cmp(tx_valid, 1'b0);
    preq_collision = 1'b0;
    // owner differs from requester, so a home entry is taken
    rx_dir_state = CID_DIR_RM;
    rxm(CID_M_IREAD_HOME, 2'h3);
    cmp(tx_dest, ~idx);
    rxm(CID_M_INTERVENTION, 2'h1);
    cmp(tx_type, CID_M_DONE);
    cmp(tx_dest, idx);
    rxm(CID_M_IREAD_HOME, 2'h3);
    rxm(CID_M_RETRY, 2'h1);
    cmp(tx_type, CID_M_READ_OWNER);
    rx_dir_state = CID_DIR_LS;
    rxm(CID_M_NOT_OWNER, 2'h1);
    cmp(tx_type, CID_M_DONE);
    cmp(dir_wr_valid, 1'b1);
    req(16'h4391);
    req(16'h00B0);
    rxm(CID_M_DONE, 2'h1);
    cmp(err, 1'b1);
    rxm(CID_M_RETRY, 2'h2);
    cmp(tx_type, CID_M_IREAD_HOME);
    rxm(CID_M_DONE, 2'h2);
    cmp(fill_valid, 1'b1);
    end_sim;
  end
endmodule : coherence_iread_rfo_directory_test
`default_nettype wire
